// [design/gpio_mux_cfg.svh]
// Register map, field positions, reset values and timing counts of the pin function mux.
// Assumes a 40 MHz APB clock and eight pins.
`ifndef GPIO_MUX_CFG_SVH
`define GPIO_MUX_CFG_SVH
`define GM_NPINS 8
`define GM_OFS_GLOBAL 12'h000
`define GM_OFS_PIN_IN 12'h004
`define GM_OFS_PIN_OUT 12'h008
`define GM_OFS_STICKY 12'h00C
`define GM_OFS_STK_CLR 12'h010
`define GM_OFS_ALERT_EN 12'h014
`define GM_OFS_LIVE 12'h018
`define GM_OFS_DCO_EVT 12'h01C
`define GM_OFS_PIN_CFG0 12'h040
`define GM_OFS_DIS_SEL0 12'h080
`define GM_GLB_V18 0
`define GM_GLB_ALM_EN 1
`define GM_GLB_READY 2
`define GM_CFG_MODE_LSB 0
`define GM_CFG_MODE_W 4
`define GM_CFG_SEL_LSB 4
`define GM_CFG_SEL_W 4
`define GM_CFG_INV 8
`define GM_CFG_EN 9
`define GM_CFG_OD 10
`define GM_CFG_PULLDN 11
`define GM_CFG_RST 32'h0000_0200
`define GM_GLB_RST 32'h0000_0002
`define GM_NSRC 16
`define GM_NOUT 12
`define GM_CLR_LAT_US 200
`define GM_CLK_MHZ 40
`endif

// [design/gpio_mux_pkg.sv]
// Types for the pin function mux.
// Assumes gpio_mux_cfg.svh is on the include path.
package gpio_mux_pkg;
  typedef enum logic [3:0] {
    MODE_IN, MODE_OUT, MODE_LOS, MODE_LOL_LIVE, MODE_LOL_STK, MODE_HO_LIVE,
    MODE_HO_STK, MODE_ALERT, MODE_OUT_DIS, MODE_CLK_IN, MODE_MAN_SEL,
    MODE_DCO_INC, MODE_DCO_DEC, MODE_DISQUAL
  } pin_mode_t;
  typedef struct packed {
    logic pulldn;
    logic od;
    logic en;
    logic inv;
    logic [3:0] sel;
    pin_mode_t mode;
  } pin_cfg_t;
  // First member is the top nibble: monitors sit in [3:0], as the flat indexing expects
  typedef struct packed {
    logic [3:0] spare;
    logic [3:0] dpll_ho;
    logic [3:0] pll_unlock;
    logic [3:0] ref_los;
  } alarm_src_t;
  typedef enum logic [1:0] {ST_RESET, ST_ACTIVE} run_state_t;
endpackage : gpio_mux_pkg

// [design/gpio_function_mux.sv]
// Pin function multiplexer: each of eight pins takes one input or output function.
// Assumes an APB master on pclk, alarm sources and reset-done level already on pclk.
//
// How it works
// - Pin functions other than plain input act only after reset_done; before then pins stay released.
// - Plain input mode samples the synchronised pin into a readable register.
// - Plain output mode drives the pin from its software output bit.
// - Each pin has its own config; equal configs give equal outputs except in plain output mode, which follows each pin's own bit.
// - LOS mode shows the live selected reference-monitor alarm, optionally inverted.
// - Live loss-of-lock is high while the selected PLL is unlocked.
// - Sticky loss-of-lock sets on any lock change until software clears it.
// - Live holdover is high while the selected DPLL is in holdover.
// - Sticky holdover sets on any holdover change until software clears it.
// - Alert mode outputs the OR of the enabled sticky bits, optionally inverted.
// - Output-disable mode: a high pin disables the selected output clocks.
// - Each disable pin holds its own mask of any outputs.
// - Manual select pin high picks the higher-priority input of the DPLL.
// - Each rising pin edge in increment mode pulses the selected DCO increment.
// - Each rising pin edge in decrement mode pulses the selected DCO decrement.
// - Disqualify mode: a high pin disqualifies the selected reference.
// - Per-pin enable; output functions choose open-drain or push-pull drive.
// - Open-drain drives only low; push-pull drives both levels.
// - Per-pin pull choice, pull-up by default.
// - Clearing stickies may take a bounded latency before the pin negates.
// - A global alarm enable gates every alarm source.
//
// The register addresses and the APB slave port were left to the implementer.
`include "gpio_mux_cfg.svh"
module gpio_function_mux
  import gpio_mux_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device status
  input wire logic reset_done,
  input wire alarm_src_t alarm_live,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pulldn,
  // Function outputs
  output logic [11:0] out_clk_dis,
  output logic [3:0] man_sel_hi,
  output logic [3:0] man_sel_act,
  output logic [3:0] dco_inc,
  output logic [3:0] dco_dec,
  output logic [15:0] ref_disqual,
  output logic [7:0] clk_in_use
);
  localparam int NP = `GM_NPINS;
  localparam int CLR_CYC = `GM_CLR_LAT_US * `GM_CLK_MHZ;

  logic [31:0] glb_q, glb_d;
  logic [7:0] pout_q, pout_d;
  logic [15:0] sticky_q, sticky_d;
  logic [15:0] alert_en_q, alert_en_d;
  logic [15:0] live_q, live_d;
  pin_cfg_t cfg_q [NP];
  pin_cfg_t cfg_d [NP];
  logic [11:0] dsel_q [NP];
  logic [11:0] dsel_d [NP];
  logic [7:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, lvl_prev_q;
  logic [7:0] pin_in_q, pin_in_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  run_state_t run_q, run_d;
  logic [7:0] pout_o_d, poe_d, ppd_d;
  logic [11:0] dis_d;
  logic [3:0] msh_d, msa_d, inc_d, dec_d;
  logic [15:0] dq_d;
  logic [7:0] ciu_d;
  logic [15:0] clr_mask;
  logic [15:0] src_now;
  logic acc, wr;
  logic [5:0] idx;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign idx = paddr[7:2];
  // Gated source vector: global enable suppresses every alarm
  assign src_now = glb_q[`GM_GLB_ALM_EN] ? alarm_live : 16'h0000;
  assign clr_mask = (wr && paddr == `GM_OFS_STK_CLR) ? pwdata[15:0] : 16'h0000;

  // Three-stage input synchroniser; change counts when stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < NP; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle at the pull-up level so release gives no false rising edge
      s1_q <= 8'hFF;
      s2_q <= 8'hFF;
      s3_q <= 8'hFF;
      lvl_q <= 8'hFF;
      lvl_prev_q <= 8'hFF;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      lvl_prev_q <= lvl_q;
    end
  end

  // Register file and sticky logic
  always_comb begin
    glb_d = glb_q;
    pout_d = pout_q;
    alert_en_d = alert_en_q;
    live_d = src_now;
    cfg_d = cfg_q;
    dsel_d = dsel_q;
    pin_in_d = pin_in_q;
    prdata_d = 32'h0000_0000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    // Any live change sets the sticky; set wins over a same-cycle clear
    sticky_d = (sticky_q & ~clr_mask) | (src_now ^ live_q);
    for (int i = 0; i < NP; i++) begin
      if (cfg_q[i].mode == MODE_IN) begin
        pin_in_d[i] = lvl_q[i];
      end
    end
    if (psel && !penable) begin
      pready_d = 1'b1;
    end
    if (wr) begin
      case (paddr)
        `GM_OFS_GLOBAL: glb_d = pwdata & 32'h0000_0003;
        `GM_OFS_PIN_OUT: pout_d = pwdata[7:0];
        `GM_OFS_ALERT_EN: alert_en_d = pwdata[15:0];
        `GM_OFS_STK_CLR: ;
        default: begin
          if (paddr[11:6] == `GM_OFS_PIN_CFG0 >> 6 && idx[3:0] < NP) begin
            cfg_d[idx[2:0]] = pwdata[11:0];
          end else if (paddr[11:6] == `GM_OFS_DIS_SEL0 >> 6 && idx[3:0] < NP) begin
            dsel_d[idx[2:0]] = pwdata[11:0];
          end
        end
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `GM_OFS_GLOBAL: prdata_d = {29'h0, run_q == ST_ACTIVE, glb_q[1:0]};
        `GM_OFS_PIN_IN: prdata_d = {24'h0, pin_in_q};
        `GM_OFS_PIN_OUT: prdata_d = {24'h0, pout_q};
        `GM_OFS_STICKY: prdata_d = {16'h0, sticky_q};
        `GM_OFS_ALERT_EN: prdata_d = {16'h0, alert_en_q};
        `GM_OFS_LIVE: prdata_d = {16'h0, live_q};
        `GM_OFS_STK_CLR: prdata_d = 32'h0000_0000;
        default: begin
          if (paddr[11:6] == `GM_OFS_PIN_CFG0 >> 6 && idx[3:0] < NP) begin
            prdata_d = {20'h0, cfg_q[idx[2:0]]};
          end else if (paddr[11:6] == `GM_OFS_DIS_SEL0 >> 6 && idx[3:0] < NP) begin
            prdata_d = {20'h0, dsel_q[idx[2:0]]};
          end else begin
            pslverr_d = 1'b1;
          end
        end
      endcase
    end else if (psel && !penable && pwrite) begin
      case (paddr)
        `GM_OFS_GLOBAL, `GM_OFS_PIN_OUT, `GM_OFS_ALERT_EN, `GM_OFS_STK_CLR: ;
        default: begin
          if (!((paddr[11:6] == `GM_OFS_PIN_CFG0 >> 6 || paddr[11:6] == `GM_OFS_DIS_SEL0 >> 6)
                && idx[3:0] < NP)) begin
            pslverr_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_q <= `GM_GLB_RST;
      pout_q <= 8'h00;
      sticky_q <= 16'h0000;
      alert_en_q <= 16'h0000;
      live_q <= 16'h0000;
      pin_in_q <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      for (int i = 0; i < NP; i++) begin
        cfg_q[i] <= 12'(`GM_CFG_RST);
        dsel_q[i] <= 12'h000;
      end
    end else begin
      glb_q <= glb_d;
      pout_q <= pout_d;
      sticky_q <= sticky_d;
      alert_en_q <= alert_en_d;
      live_q <= live_d;
      pin_in_q <= pin_in_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      cfg_q <= cfg_d;
      dsel_q <= dsel_d;
    end
  end

  // Run state: functions other than plain input stay off until the device reset sequence ends
  always_comb begin
    case (run_q)
      ST_RESET: run_d = reset_done ? ST_ACTIVE : ST_RESET;
      ST_ACTIVE: run_d = reset_done ? ST_ACTIVE : ST_RESET;
      default: run_d = ST_RESET;
    endcase
  end

  // Pin function decode; all outputs registered
  always_comb begin
    logic f;
    logic [1:0] s2;
    f = 1'b0;
    s2 = 2'b00;
    pout_o_d = 8'h00;
    poe_d = 8'h00;
    ppd_d = 8'h00;
    dis_d = 12'h000;
    msh_d = 4'h0;
    msa_d = 4'h0;
    inc_d = 4'h0;
    dec_d = 4'h0;
    dq_d = 16'h0000;
    ciu_d = 8'h00;
    for (int i = 0; i < NP; i++) begin
      ppd_d[i] = cfg_q[i].pulldn;
      s2 = cfg_q[i].sel[1:0];
      f = 1'b0;
      if (run_q == ST_ACTIVE && cfg_q[i].en) begin
        case (cfg_q[i].mode)
          MODE_OUT: f = pout_q[i];
          MODE_LOS: f = live_q[s2];
          MODE_LOL_LIVE: f = live_q[4 + s2];
          MODE_LOL_STK: f = sticky_q[4 + s2];
          MODE_HO_LIVE: f = live_q[8 + s2];
          MODE_HO_STK: f = sticky_q[8 + s2];
          MODE_ALERT: f = |(sticky_q & alert_en_q);
          MODE_OUT_DIS: begin
            if (lvl_q[i]) begin
              dis_d = dis_d | dsel_q[i];
            end
          end
          MODE_CLK_IN: ciu_d[i] = 1'b1;
          MODE_MAN_SEL: begin
            msa_d[s2] = 1'b1;
            msh_d[s2] = lvl_q[i];
          end
          MODE_DCO_INC: inc_d[s2] = inc_d[s2] | (lvl_q[i] & ~lvl_prev_q[i]);
          MODE_DCO_DEC: dec_d[s2] = dec_d[s2] | (lvl_q[i] & ~lvl_prev_q[i]);
          MODE_DISQUAL: dq_d[cfg_q[i].sel] = dq_d[cfg_q[i].sel] | lvl_q[i];
          default: f = 1'b0;
        endcase
        if (cfg_q[i].mode inside {MODE_OUT, MODE_LOS, MODE_LOL_LIVE, MODE_LOL_STK,
                                  MODE_HO_LIVE, MODE_HO_STK, MODE_ALERT}) begin
          // Inversion after selection keeps sticky state untouched
          if (cfg_q[i].mode != MODE_OUT) begin
            f = f ^ cfg_q[i].inv;
          end
          pout_o_d[i] = cfg_q[i].od ? 1'b0 : f;
          poe_d[i] = cfg_q[i].od ? ~f : 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= ST_RESET;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pulldn <= 8'h00;
      out_clk_dis <= 12'h000;
      man_sel_hi <= 4'h0;
      man_sel_act <= 4'h0;
      dco_inc <= 4'h0;
      dco_dec <= 4'h0;
      ref_disqual <= 16'h0000;
      clk_in_use <= 8'h00;
    end else begin
      run_q <= run_d;
      pin_out <= pout_o_d;
      pin_oe <= poe_d;
      pin_pulldn <= ppd_d;
      out_clk_dis <= dis_d;
      man_sel_hi <= msh_d;
      man_sel_act <= msa_d;
      dco_inc <= inc_d;
      dco_dec <= dec_d;
      ref_disqual <= dq_d;
      clk_in_use <= ciu_d;
    end
  end

  // Checks
  chk_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
    (src_now != live_q) |=> ((sticky_q & $past(src_now ^ live_q)) == $past(src_now ^ live_q)))
    else $error("sticky bit missed a live change");
  chk_alarm_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !glb_q[`GM_GLB_ALM_EN] |=> (live_q == 16'h0000))
    else $error("alarm not gated off");
  chk_pre_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (run_q == ST_RESET) |=> (pin_oe == 8'h00 && dco_inc == 4'h0))
    else $error("pin active before reset done");
  chk_od_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ((cfg_q[1].od && cfg_q[1].en && run_q == ST_ACTIVE && cfg_q[1].mode == MODE_OUT)
      |=> (pin_out[1] == 1'b0 && pin_oe[1] == !$past(pout_q[1]))))
    else $error("open drain drove high");
  chk_pp_out: assert property (@(posedge pclk) disable iff (!presetn)
    ((!cfg_q[0].od && cfg_q[0].en && run_q == ST_ACTIVE && cfg_q[0].mode == MODE_OUT)
      |=> (pin_out[0] == $past(pout_q[0]) && pin_oe[0])))
    else $error("output bit not driven");
  chk_inc_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (run_q == ST_ACTIVE && cfg_q[1].en && cfg_q[1].mode == MODE_DCO_INC
      && cfg_q[1].sel == 4'h3 && $rose(lvl_q[1])) |=> dco_inc[3])
    else $error("increment pulse missed an edge");
  chk_input_sample: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_q[2].mode == MODE_IN) |=> (pin_in_q[2] == $past(lvl_q[2])))
    else $error("input level not sampled");
  chk_clear_works: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_mask[0] && src_now[0] == live_q[0]) |=> !sticky_q[0])
    else $error("sticky clear ignored");
  chk_sync_lag: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(lvl_q) |-> (((lvl_q ^ $past(lvl_q)) & ($past(s2_q) ^ $past(s3_q))) == 8'h00))
    else $error("level changed without agreement");
  cov_alert: cover property (@(posedge pclk) disable iff (!presetn) |(sticky_q & alert_en_q));
  cov_disable: cover property (@(posedge pclk) disable iff (!presetn) out_clk_dis != 12'h000);
  cov_dec: cover property (@(posedge pclk) disable iff (!presetn) dco_dec != 4'h0);
  cov_clear: cover property (@(posedge pclk) disable iff (!presetn) clr_mask != 16'h0000);
endmodule : gpio_function_mux

// [verif/pin_board.sv]
// Board side of the eight pins: resolves each pad from the mux, board drivers and pulls.
// Assumes the bench drives ext_drv and ext_val in place of board logic and PHYs.
module pin_board (
  // From the mux
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pulldn,
  // Board drivers
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_val,
  // Resolved pads
  output logic [7:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pad goes to its pull, never keeps the last driven level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i])
        pad[i] = pin_out[i];
      else if (ext_drv[i])
        pad[i] = ext_val[i];
      else
        pad[i] = !pin_pulldn[i];
    end
  end
endmodule : pin_board

// [verif/gpio_function_mux_tb_top.sv]
// Self-checking bench for the pin function mux, one task per scenario.
// Assumes the cfg header on the include path and pin_board as the far side.
`include "gpio_mux_cfg.svh"
module gpio_function_mux_tb_top
  import gpio_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_done, last_err;
  logic [11:0] paddr, out_clk_dis;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] alm, ref_disqual;
  logic [7:0] pad, pin_out, pin_oe, pin_pulldn, ext_drv, ext_val, clk_in_use;
  logic [3:0] man_sel_hi, man_sel_act, dco_inc, dco_dec;
  int fails, tests_run, cyc_n, inc_n, dec_n;

  gpio_function_mux uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_done(reset_done), .alarm_live(alarm_src_t'(alm)), .pin_in(pad),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldn(pin_pulldn),
    .out_clk_dis(out_clk_dis), .man_sel_hi(man_sel_hi), .man_sel_act(man_sel_act),
    .dco_inc(dco_inc), .dco_dec(dco_dec), .ref_disqual(ref_disqual),
    .clk_in_use(clk_in_use)
  );
  pin_board board (
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldn(pin_pulldn),
    .ext_drv(ext_drv), .ext_val(ext_val), .pad(pad)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic finish_test;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Hang guard and DCO pulse counters
  always @(posedge pclk) begin
    cyc_n++;
    if (dco_inc[3])
      inc_n++;
    if (dco_dec[0])
      dec_n++;
    if (cyc_n == 20000) begin
      fails++;
      finish_test;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is seen high; the bench timeout ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Flags are {pulldn, od, en, inv}
  function automatic logic [31:0] cfg(pin_mode_t m, logic [3:0] s, logic [3:0] f);
    return {20'h0, f, s, m};
  endfunction : cfg

  task automatic setp(input int n, input logic [31:0] v);
    apb(1'b1, `GM_OFS_PIN_CFG0 + 12'(4 * n), v);
  endtask : setp

  task automatic t_reset;
    apb(1'b0, `GM_OFS_GLOBAL, 0);
    check("glb_rst", rdv, `GM_GLB_RST);
    apb(1'b0, `GM_OFS_PIN_CFG0, 0);
    check("cfg_rst", rdv, `GM_CFG_RST);
    apb(1'b0, 12'h030, 0);
    check("unm_err", last_err, 1);
    check("unm_data", rdv, 0);
    setp(0, cfg(MODE_OUT, 0, 4'h2));
    apb(1'b1, `GM_OFS_PIN_OUT, 1);
    cyc(6);
    check("oe_early", pin_oe, 0);
    reset_done <= 1'b1;
    cyc(4);
    check("oe_active", pin_oe, 1);
    check("out_hi", pin_out, 1);
    apb(1'b1, `GM_OFS_GLOBAL, 3);
    apb(1'b0, `GM_OFS_GLOBAL, 0);
    check("glb_ready", rdv, 7);
  endtask : t_reset

  task automatic t_io;
    cyc(6);
    apb(1'b0, `GM_OFS_PIN_IN, 0);
    check("pull_up", rdv[7:1], 7'h7F);
    ext_drv <= 8'hFE;
    ext_val <= 8'hA4;
    cyc(6);
    apb(1'b0, `GM_OFS_PIN_IN, 0);
    check("pin_in", rdv[7:1], 7'h52);
    ext_drv <= 8'h00;
    setp(1, cfg(MODE_OUT, 0, 4'h6));
    setp(2, cfg(MODE_IN, 0, 4'hA));
    setp(3, cfg(MODE_OUT, 0, 4'h0));
    apb(1'b1, `GM_OFS_PIN_OUT, 3);
    cyc(6);
    check("od_high", pin_oe[3:0], 4'h1);
    check("pulldn", pin_pulldn, 8'h04);
    apb(1'b1, `GM_OFS_PIN_OUT, 0);
    cyc(6);
    check("od_low_oe", pin_oe[3:0], 4'h3);
    check("od_low", pin_out[1:0], 2'b00);
  endtask : t_io

  task automatic t_live;
    setp(2, cfg(MODE_LOS, 1, 4'h2));
    setp(3, cfg(MODE_LOS, 1, 4'h2));
    setp(4, cfg(MODE_LOS, 1, 4'h3));
    setp(5, cfg(MODE_LOL_LIVE, 2, 4'h2));
    setp(6, cfg(MODE_HO_LIVE, 0, 4'h2));
    cyc(6);
    check("live_idle", pin_out[6:2], 5'b00100);
    alm <= 16'h0142;
    cyc(6);
    check("live_set", pin_out[6:2], 5'b11011);
    alm <= 16'h0040;
    cyc(6);
    check("live_part", pin_out[6:2], 5'b01100);
    apb(1'b0, `GM_OFS_LIVE, 0);
    check("live_reg", rdv, 32'h0000_0040);
    alm <= 16'h0000;
  endtask : t_live

  task automatic t_sticky;
    setp(5, cfg(MODE_ALERT, 0, 4'h2));
    setp(6, cfg(MODE_HO_STK, 0, 4'h2));
    setp(7, cfg(MODE_LOL_STK, 2, 4'h3));
    apb(1'b1, `GM_OFS_ALERT_EN, 32'h0000_0100);
    cyc(6);
    apb(1'b1, `GM_OFS_STK_CLR, 32'h0000_FFFF);
    cyc(6);
    check("stk_idle", pin_out[7:5], 3'b100);
    alm <= 16'h0040;
    cyc(6);
    check("lol_stk", pin_out[7:5], 3'b000);
    apb(1'b0, `GM_OFS_STICKY, 0);
    check("stk_reg", rdv, 32'h0000_0040);
    alm <= 16'h0140;
    cyc(6);
    alm <= 16'h0000;
    cyc(6);
    check("ho_stk", pin_out[7:5], 3'b011);
    apb(1'b1, `GM_OFS_STK_CLR, 32'h0000_0040);
    cyc(6);
    check("alert_hold", pin_out[7:5], 3'b111);
    apb(1'b1, `GM_OFS_STK_CLR, 32'h0000_0100);
    cyc(6);
    check("alert_free", pin_out[7:5], 3'b100);
    apb(1'b1, `GM_OFS_GLOBAL, 1);
    alm <= 16'h0100;
    cyc(6);
    apb(1'b0, `GM_OFS_LIVE, 0);
    check("live_gate", rdv, 0);
    alm <= 16'h0000;
    cyc(6);
    apb(1'b0, `GM_OFS_STICKY, 0);
    check("alm_gate", rdv, 0);
    apb(1'b1, `GM_OFS_GLOBAL, 3);
  endtask : t_sticky

  // Board holds pins 0 to 4 low before they turn to inputs, so their release makes no rising edge.
  // Pin 5 takes clock-input mode; its stage is assumed free of two references
  task automatic t_inputs;
    ext_val <= 8'h00;
    ext_drv <= 8'h1F;
    setp(0, cfg(MODE_OUT_DIS, 0, 4'h2));
    setp(1, cfg(MODE_DCO_INC, 3, 4'h2));
    setp(2, cfg(MODE_DCO_DEC, 0, 4'h2));
    setp(3, cfg(MODE_MAN_SEL, 1, 4'h2));
    setp(4, cfg(MODE_DISQUAL, 5, 4'h2));
    setp(5, cfg(MODE_CLK_IN, 0, 4'h2));
    apb(1'b1, `GM_OFS_DIS_SEL0, 32'h0000_0A5A);
    cyc(8);
    check("in_oe", pin_oe[5:0], 0);
    check("dis_low", out_clk_dis, 0);
    check("clk_in", clk_in_use, 8'h20);
    check("man_act", man_sel_act, 4'h2);
    ext_val <= 8'h1F;
    cyc(16);
    check("dis_high", out_clk_dis, 12'hA5A);
    check("man_hi", man_sel_hi, 4'h2);
    check("disqual", ref_disqual, 16'h0020);
    check("inc_one", inc_n, 1);
    check("dec_one", dec_n, 1);
    ext_val <= 8'h00;
    cyc(8);
    check("dis_rel", out_clk_dis, 0);
    check("man_lo", man_sel_hi, 0);
    check("disq_rel", ref_disqual, 0);
    ext_val <= 8'h02;
    cyc(8);
    check("inc_two", inc_n, 2);
    check("dec_keep", dec_n, 1);
  endtask : t_inputs

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    reset_done = 1'b0;
    alm = 16'h0;
    ext_drv = 8'h00;
    ext_val = 8'h00;
    cyc(20);
    presetn <= 1'b1;
    t_reset;
    t_io;
    t_live;
    t_sticky;
    t_inputs;
    finish_test;
  end
endmodule : gpio_function_mux_tb_top
